// ---- rtl/rair_remap.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "rair_defines.svh"

// What this block does
// R1: each alias slot keeps a writable 7-bit alias in bits 7-1 that resets to zero.
// R2: every local transaction address is compared against all alias slots, and a match means a remote target.
// R3: on a match the address is replaced by the paired target address before forwarding.
// R4: alias slot n pairs with target register n for slots 1 to 5.
// R5: an alias of zero disables its slot, so it never matches or forwards.
// R6: the alias slots sit at byte addresses 0x11 to 0x15 and their bit 0 reads as zero.
// R7: each target register keeps the remote slave's 7-bit address in bits 7-1 and resets to zero.
// R8: the remapped transaction is passed on over the control channel to the remote serializer.
// R9: an address that hits no enabled slot is not forwarded by this block.
module rair_remap
    import rair_pkg::*;
(
    // clock, reset, enable
    input wire logic I_CORE_CLK,
    input wire logic I_RST_N,
    input wire logic I_CE,
    // register port from the local slave engine
    input wire logic I_REG_WR,
    input wire logic I_REG_RD,
    input wire logic [7:0] I_REG_ADDR,
    input wire logic [7:0] I_REG_WDATA,
    output logic [7:0] O_REG_RDATA,
    output logic O_REG_MAPPED,
    // local bus transaction events
    input wire logic I_ADDR_VALID,
    input wire logic [7:0] I_ADDR_BYTE,
    input wire logic I_DATA_VALID,
    input wire logic [7:0] I_DATA,
    input wire logic I_STOP,
    // control channel side
    output logic O_FWD_START,
    output logic [6:0] O_FWD_ADDR,
    output logic O_FWD_RW,
    output logic O_FWD_DVALID,
    output logic [7:0] O_FWD_DATA,
    output logic O_FWD_END,
    output logic O_FWD_BUSY,
    output logic O_MISS
);

    localparam int NSLOT = `RAIR_SLOTS;
    localparam logic [7:0] ALIAS_OFFS [NSLOT] = '{`RAIR_ALIAS_1_OFF, `RAIR_ALIAS_2_OFF,
        `RAIR_ALIAS_3_OFF, `RAIR_ALIAS_4_OFF, `RAIR_ALIAS_5_OFF};
    localparam logic [7:0] TARGET_OFFS [NSLOT] = '{`RAIR_TARGET_1_OFF, `RAIR_TARGET_2_OFF,
        `RAIR_TARGET_3_OFF, `RAIR_TARGET_4_OFF, `RAIR_TARGET_5_OFF};

    rair_state_t state_r;
    rair_state_t state_nxt;
    rair_addr7_t alias_v [NSLOT];
    rair_addr7_t target_v [NSLOT];
    logic [NSLOT-1:0] hit_v;
    logic [NSLOT-1:0] alias_sel_v;
    logic [NSLOT-1:0] target_sel_v;

    wire rair_addr7_t cmp_addr = I_ADDR_BYTE[`RAIR_ADDR_MSB:`RAIR_ADDR_LSB];
    wire cmp_rw = I_ADDR_BYTE[`RAIR_RSVD_BIT];

    genvar g;
    generate
        for (g = 0; g < NSLOT; g++) begin : g_slot
            rair_slot #(
                .ALIAS_OFF(ALIAS_OFFS[g]),
                .TARGET_OFF(TARGET_OFFS[g])
            ) u_slot (
                .i_clk(I_CORE_CLK),
                .i_rst_n(I_RST_N),
                .i_ce(I_CE),
                .i_wr(I_REG_WR),
                .i_addr(I_REG_ADDR),
                .i_wdata(I_REG_WDATA),
                .i_cmp_addr(cmp_addr),
                .o_alias(alias_v[g]),
                .o_target(target_v[g]),
                .o_hit(hit_v[g])
            );
            assign alias_sel_v[g] = (I_REG_ADDR == ALIAS_OFFS[g]);
            assign target_sel_v[g] = (I_REG_ADDR == TARGET_OFFS[g]);
        end
    endgenerate

    // lowest slot wins if software programs the same alias twice
    rair_addr7_t sel_target;
    rair_addr7_t rd_field;
    always_comb begin
        sel_target = `RAIR_ADDR_RST;
        for (int i = NSLOT - 1; i >= 0; i--) begin
            if (hit_v[i]) begin
                sel_target = target_v[i]; // R3 R4
            end
        end
    end

    always_comb begin
        rd_field = `RAIR_ADDR_RST;
        for (int i = 0; i < NSLOT; i++) begin
            if (alias_sel_v[i]) begin
                rd_field = alias_v[i];
            end
            if (target_sel_v[i]) begin
                rd_field = target_v[i];
            end
        end
    end

    wire hit_any = |hit_v; // R2
    wire rd_mapped = (|alias_sel_v) || (|target_sel_v);
    // bit 0 is tied low, so reserved bits never echo a write
    wire [7:0] rd_byte = {rd_field, 1'b0}; // R6
    wire addr_take = I_ADDR_VALID && hit_any;
    wire addr_miss = I_ADDR_VALID && !hit_any;

    // a repeated start inside a forward re-evaluates the new address
    always_comb begin
        case (state_r)
            RAIR_IDLE: state_nxt = addr_take ? RAIR_FWD : RAIR_IDLE;
            RAIR_FWD: begin
                if (I_ADDR_VALID) begin
                    state_nxt = hit_any ? RAIR_FWD : RAIR_IDLE;
                end else if (I_STOP) begin
                    state_nxt = RAIR_IDLE;
                end else begin
                    state_nxt = RAIR_FWD;
                end
            end
            default: state_nxt = RAIR_IDLE;
        endcase
    end

    wire fwd_data = (state_r == RAIR_FWD) && I_DATA_VALID && !I_ADDR_VALID; // R8
    wire fwd_end = (state_r == RAIR_FWD) && (state_nxt == RAIR_IDLE);

    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RST_N) begin
            state_r <= RAIR_IDLE;
            O_FWD_START <= 1'b0;
            O_FWD_ADDR <= `RAIR_ADDR_RST;
            O_FWD_RW <= 1'b0;
            O_FWD_DVALID <= 1'b0;
            O_FWD_DATA <= `RAIR_BYTE_RST;
            O_FWD_END <= 1'b0;
            O_MISS <= 1'b0;
        end else if (I_CE) begin
            state_r <= state_nxt;
            O_FWD_START <= addr_take; // R8
            O_FWD_DVALID <= fwd_data;
            O_FWD_END <= fwd_end;
            O_MISS <= addr_miss; // R9
            if (addr_take) begin
                O_FWD_ADDR <= sel_target; // R3
                O_FWD_RW <= cmp_rw;
            end
            if (fwd_data) begin
                O_FWD_DATA <= I_DATA; // R8
            end
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RST_N) begin
            O_REG_RDATA <= `RAIR_BYTE_RST;
            O_REG_MAPPED <= 1'b0;
        end else if (I_CE && I_REG_RD) begin
            O_REG_RDATA <= rd_byte; // R6
            O_REG_MAPPED <= rd_mapped;
        end
    end

    assign O_FWD_BUSY = (state_r == RAIR_FWD);

    a_fwd_addr_subst: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N) // R3
        (I_CE && I_ADDR_VALID && hit_v == 5'h10) |=> (O_FWD_START && O_FWD_ADDR == $past(target_v[4])))
        else $error("slot 5 hit did not forward target 5");

    a_slot_pairing: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N) // R4
        (I_CE && I_ADDR_VALID && hit_v[0]) |=> (O_FWD_ADDR == $past(target_v[0])))
        else $error("slot 1 hit did not use target 1");

    a_miss_no_fwd: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N) // R9
        (I_CE && addr_miss) |=> (O_MISS && !O_FWD_START))
        else $error("unmatched address was forwarded");

    a_restart_miss: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N) // R9
        (I_CE && O_FWD_BUSY && addr_miss) |=> (O_FWD_END && O_MISS && !O_FWD_BUSY && !O_FWD_START))
        else $error("missed repeated start did not end forwarding");

    a_zero_disables: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N) // R5
        (cmp_addr == `RAIR_DISABLED) |-> !hit_any)
        else $error("zero alias produced a match");

    a_match_hits: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N) // R2
        (alias_v[4] != `RAIR_DISABLED && cmp_addr == alias_v[4]) |-> hit_any)
        else $error("programmed alias did not match");

    a_alias_reset: assert property (@(posedge I_CORE_CLK) // R1
        !I_RST_N |=> (alias_v[0] == `RAIR_ADDR_RST && alias_v[4] == `RAIR_ADDR_RST
            && target_v[2] == `RAIR_ADDR_RST))
        else $error("alias or target not zero after reset");

    a_alias_rdback: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N) // R6
        (I_CE && I_REG_RD && I_REG_ADDR == `RAIR_ALIAS_3_OFF) |=>
            (O_REG_RDATA == {alias_v[2], 1'b0} && O_REG_MAPPED))
        else $error("alias 3 readback wrong or bit 0 set");

    a_write_stores: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N) // R7
        (I_CE && I_REG_WR && I_REG_ADDR == `RAIR_TARGET_5_OFF) |=>
            (target_v[4] == $past(I_REG_WDATA[7:1])))
        else $error("target 5 write not stored");

    a_stop_ends: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N) // R8
        (I_CE && O_FWD_BUSY && I_STOP && !I_ADDR_VALID) |=> (O_FWD_END && !O_FWD_BUSY))
        else $error("stop did not end forwarding");

    a_ce_freeze: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
        !I_CE |=> ($stable(O_FWD_ADDR) && $stable(state_r) && $stable(O_REG_RDATA)
            && $stable(alias_v[0])))
        else $error("state moved while clock enable low");

endmodule
`default_nettype wire

// ---- rtl/rair_defines.svh ----
`ifndef RAIR_DEFINES_SVH
`define RAIR_DEFINES_SVH

// alias slot byte addresses
`define RAIR_ALIAS_1_OFF 8'h11
`define RAIR_ALIAS_2_OFF 8'h12
`define RAIR_ALIAS_3_OFF 8'h13
`define RAIR_ALIAS_4_OFF 8'h14
`define RAIR_ALIAS_5_OFF 8'h15

// paired target address registers
`define RAIR_TARGET_1_OFF 8'h09
`define RAIR_TARGET_2_OFF 8'h0A
`define RAIR_TARGET_3_OFF 8'h0B
`define RAIR_TARGET_4_OFF 8'h0C
`define RAIR_TARGET_5_OFF 8'h0D

// field layout and reset values
`define RAIR_ADDR_MSB 7
`define RAIR_ADDR_LSB 1
`define RAIR_RSVD_BIT 0
`define RAIR_ADDR_RST 7'h00
`define RAIR_BYTE_RST 8'h00
`define RAIR_DISABLED 7'h00
`define RAIR_SLOTS 5

`endif

// ---- rtl/rair_pkg.sv ----
package rair_pkg;

    typedef logic [6:0] rair_addr7_t;

    typedef enum logic [0:0] {
        RAIR_IDLE = 1'b0,
        RAIR_FWD = 1'b1
    } rair_state_t;

endpackage

// ---- rtl/rair_slot.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "rair_defines.svh"

module rair_slot
    import rair_pkg::*;
#(
    parameter logic [7:0] ALIAS_OFF = 8'h00,
    parameter logic [7:0] TARGET_OFF = 8'h00
) (
    // clock, reset and enable
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // register write
    input wire logic i_wr,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    // compare
    input wire rair_addr7_t i_cmp_addr,
    output rair_addr7_t o_alias,
    output rair_addr7_t o_target,
    output logic o_hit
);

    rair_addr7_t alias_r;
    rair_addr7_t target_r;
    wire alias_wr = i_wr && (i_addr == ALIAS_OFF);
    wire target_wr = i_wr && (i_addr == TARGET_OFF);
    wire slot_enabled = (alias_r != `RAIR_DISABLED); // R5

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            alias_r <= `RAIR_ADDR_RST; // R1
            target_r <= `RAIR_ADDR_RST; // R7
        end else if (i_ce) begin
            if (alias_wr) begin
                alias_r <= i_wdata[`RAIR_ADDR_MSB:`RAIR_ADDR_LSB]; // R1
            end
            if (target_wr) begin
                target_r <= i_wdata[`RAIR_ADDR_MSB:`RAIR_ADDR_LSB]; // R7
            end
        end
    end

    assign o_hit = slot_enabled && (i_cmp_addr == alias_r); // R2 R5
    assign o_alias = alias_r;
    assign o_target = target_r;

endmodule
`default_nettype wire

// ---- dv/rair_remote_model.sv ----
`timescale 1ns/10ps
`default_nettype none

module rair_remote_model (
    // control channel from the remap block
    input wire logic i_clk,
    input wire logic i_start,
    input wire logic [6:0] i_addr,
    input wire logic i_dvalid,
    input wire logic [7:0] i_data,
    input wire logic i_end,
    // what the remote bus carried out
    output logic [6:0] o_last_addr,
    output logic [7:0] o_last_data,
    output var int o_starts,
    output var int o_ends
);
    initial begin
        o_last_addr = 7'h00;
        o_last_data = 8'h00;
        o_starts = 0;
        o_ends = 0;
    end
    // replays each remapped transfer on the remote bus
    always @(posedge i_clk) begin
        if (i_start) begin
            o_last_addr <= i_addr;
            o_starts <= o_starts + 1;
        end
        if (i_dvalid) begin
            o_last_data <= i_data;
        end
        if (i_end) begin
            o_ends <= o_ends + 1;
        end
    end
endmodule

`default_nettype wire

// ---- dv/tb.sv ----
`timescale 1ns/10ps
`default_nettype none

`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin miscompares++; \
    $display("unexpected %0t value differs", $time); end end

module tb;
    logic clk, rst_n, ce, wr, rd, av, dv, stp;
    logic [7:0] addr, wdata, abyte, data, rdata;
    logic mapped, f_start, f_rw, f_dv, f_end, f_busy, miss;
    logic [6:0] f_addr, m_addr, k;
    logic [7:0] f_data, m_data;
    int m_starts, m_ends, cycles, miscompares, compares;

    rair_remap rair_remap_i (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_CE(ce), .I_REG_WR(wr), .I_REG_RD(rd),
        .I_REG_ADDR(addr), .I_REG_WDATA(wdata), .O_REG_RDATA(rdata), .O_REG_MAPPED(mapped),
        .I_ADDR_VALID(av), .I_ADDR_BYTE(abyte), .I_DATA_VALID(dv), .I_DATA(data), .I_STOP(stp),
        .O_FWD_START(f_start), .O_FWD_ADDR(f_addr), .O_FWD_RW(f_rw), .O_FWD_DVALID(f_dv),
        .O_FWD_DATA(f_data), .O_FWD_END(f_end), .O_FWD_BUSY(f_busy), .O_MISS(miss));

    rair_remote_model rair_remote_model_i (.i_clk(clk), .i_start(f_start), .i_addr(f_addr), .i_dvalid(f_dv),
        .i_data(f_data), .i_end(f_end), .o_last_addr(m_addr), .o_last_data(m_data),
        .o_starts(m_starts), .o_ends(m_ends));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic summarize();
        if (miscompares == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // one-cycle strobes; reg_wr ends on an edge, reg_rd and ev 1 ns after one, so the next call waits one edge
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1; addr <= a; wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp, input logic map);
        @(posedge clk);
        rd <= 1'b1; addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        `CHK(rdata, exp)
        `CHK(mapped, map)
    endtask

    task automatic ev(input logic [1:0] kind, input logic [7:0] b);
        @(posedge clk);
        av <= (kind == 2'h0); dv <= (kind == 2'h1); stp <= (kind == 2'h2);
        abyte <= b; data <= b;
        @(posedge clk);
        av <= 1'b0; dv <= 1'b0; stp <= 1'b0;
        #1;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares++;
            summarize();
        end
    end

    initial begin
        cycles = 0; miscompares = 0; compares = 0;
        rst_n = 1'b0; wr = 1'b0; rd = 1'b0; av = 1'b0; dv = 1'b0; stp = 1'b0;
        addr = 8'h00; wdata = 8'h00; abyte = 8'h00; data = 8'h00; k = 7'h00;
        ce = 1'b1;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            k = 7'(i);
            reg_rd(8'h11 + {1'b0, k}, 8'h00, 1'b1);
            reg_rd(8'h09 + {1'b0, k}, 8'h00, 1'b1);
        end
        // bit 0 written high must read back low
        for (int i = 0; i < 5; i++) begin
            k = 7'(i);
            reg_wr(8'h11 + {1'b0, k}, {7'h20 + k, 1'b1});
            reg_wr(8'h09 + {1'b0, k}, {7'h40 + k, 1'b1});
        end
        for (int i = 0; i < 5; i++) begin
            k = 7'(i);
            reg_rd(8'h11 + {1'b0, k}, {7'h20 + k, 1'b0}, 1'b1);
            reg_rd(8'h09 + {1'b0, k}, {7'h40 + k, 1'b0}, 1'b1);
        end
        // unmapped reads follow a nonzero read so stale data would show
        reg_rd(8'h16, 8'h00, 1'b0);
        reg_rd(8'h10, 8'h00, 1'b0);
        for (int i = 0; i < 5; i++) begin
            k = 7'(i);
            ev(2'h0, {7'h20 + k, k[0]});
            `CHK(f_start, 1'b1)
            `CHK(f_addr, 7'h40 + k)
            `CHK(f_rw, k[0])
            `CHK(f_busy, 1'b1)
            ev(2'h1, 8'hA0 + {1'b0, k});
            `CHK(f_dv, 1'b1)
            `CHK(f_data, 8'hA0 + {1'b0, k})
            ev(2'h2, 8'h00);
            `CHK(f_end, 1'b1)
            @(posedge clk);
            #1;
            `CHK(f_busy, 1'b0)
            `CHK(m_addr, 7'h40 + k)
            `CHK(m_starts, i + 1)
            `CHK(m_ends, i + 1)
        end
        // repeated start to another slot, then one that misses
        ev(2'h0, {7'h20, 1'b0});
        ev(2'h0, {7'h24, 1'b1});
        `CHK(f_start, 1'b1)
        `CHK(f_addr, 7'h44)
        `CHK(f_end, 1'b0)
        ev(2'h0, {7'h66, 1'b0});
        `CHK(f_end, 1'b1)
        `CHK(miss, 1'b1)
        `CHK(f_start, 1'b0)
        `CHK(f_busy, 1'b0)
        // clock enable low: write and address both ignored
        @(posedge clk);
        ce <= 1'b0;
        reg_wr(8'h11, 8'h7E);
        ev(2'h0, {7'h20, 1'b0});
        `CHK(f_start, 1'b0)
        `CHK(miss, 1'b0)
        `CHK(f_busy, 1'b0)
        @(posedge clk);
        ce <= 1'b1;
        reg_rd(8'h11, {7'h20, 1'b0}, 1'b1);
        // disabled slot and unknown addresses go nowhere
        reg_wr(8'h13, 8'h00);
        ev(2'h0, {7'h22, 1'b0});
        `CHK(miss, 1'b1)
        `CHK(f_start, 1'b0)
        ev(2'h0, 8'h00);
        `CHK(miss, 1'b1)
        ev(2'h0, {7'h55, 1'b1});
        `CHK(miss, 1'b1)
        ev(2'h1, 8'h3C);
        `CHK(f_dv, 1'b0)
        // duplicate alias: the lower slot wins
        reg_wr(8'h15, {7'h21, 1'b0});
        ev(2'h0, {7'h21, 1'b0});
        `CHK(f_start, 1'b1)
        `CHK(f_addr, 7'h41)
        ev(2'h2, 8'h00);
        `CHK(f_end, 1'b1)
        @(posedge clk);
        #1;
        `CHK(m_starts, 8)
        `CHK(m_ends, 7)
        `CHK(m_addr, 7'h41)
        summarize();
    end
endmodule

`default_nettype wire
